//--- rtl/uaf_flag.sv
/*
  Sticky unaligned trap flag within the configurable fault status word.
  Holds the flag register, its write-one-to-clear decode, a registered
  fault strobe and the checks that guard them.
  Assumes the processor clock, a synchronous active-low reset, and that
  the write path and access reports are synchronous to CLK, so no
  synchroniser sits on any input.
  Other fault status bits live elsewhere and are not decoded here.
*/
`timescale 1ns/1ps
`default_nettype none

module uaf_flag
(
  // Clock and reset
  input  wire logic                 CLK,
  input  wire logic                 RST_N,
  // Load/store access report
  input  wire uaf_pkg::uaf_access_t ACCESS,
  // Trap enable from the control register
  input  wire logic                 TRAP_EN,
  // Register write path
  input  wire uaf_pkg::uaf_wr_t     WR,
  // Status outputs
  output logic                      UNALIGNED_TRAP_FLAG,
  output logic                      FAULT_PULSE
);
  import uaf_pkg::*;

  // ----------------------------------------------------------------------
  // Fault detection
  // ----------------------------------------------------------------------
  // Decision, decode and state
  logic fault;
  logic addr_hit;
  logic bit_hit;
  logic clr_hit;
  logic flag_q;
  logic flag_d;
  logic pulse_q;

  // Classification kept apart so other fault bits can share it
  uaf_trap_decide u_decide (
    .acc     (ACCESS),
    .trap_en (TRAP_EN),
    .fault   (fault)
  );

  // Write-one-to-clear decode at the flag's position
  // Only the full word offset is matched; byte lanes are not modelled
  assign addr_hit = WR.wr_en && (WR.addr == UAF_STATUS_OFFSET);
  assign bit_hit  = WR.wdata[UAF_FLAG_BIT];
  assign clr_hit  = addr_hit && bit_hit;

  // ----------------------------------------------------------------------
  // Sticky flag
  // ----------------------------------------------------------------------
  // Set wins over clear so a fault in the clearing cycle is not lost
  always_comb
  begin
    flag_d = flag_q;
    if (clr_hit)
    begin
      flag_d = 1'b0;
    end
    if (fault)
    begin
      flag_d = 1'b1;
    end
  end

  // Flag register, synchronous reset only
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      flag_q <= UAF_FLAG_RESET;
    end
    else
    begin
      flag_q <= flag_d;
    end
  end

  // Registered fault strobe for the exception entry logic
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      pulse_q <= 1'b0;
    end
    else
    begin
      pulse_q <= fault;
    end
  end

  // Outputs straight from the flops, no logic after them
  assign UNALIGNED_TRAP_FLAG = flag_q;
  assign FAULT_PULSE         = pulse_q;

  // ----------------------------------------------------------------------
  // Checks: setting the flag
  // ----------------------------------------------------------------------
  // Only design-driven values are judged; the access report and write
  // path are taken as given from the load/store unit.

  // Wide transfers cannot be split, so they fault with trapping off
  multi_always_a : assert property (@(posedge CLK) disable iff (!RST_N)
    (ACCESS.valid && ACCESS.unaligned &&
     (ACCESS.kind == UAF_KIND_MULTI || ACCESS.kind == UAF_KIND_DUAL)) |=> UNALIGNED_TRAP_FLAG)
    else $error("multi or dual unaligned access did not set flag");

  // A clear flag stays clear without a trapping access
  single_gated_a : assert property (@(posedge CLK) disable iff (!RST_N)
    (!UNALIGNED_TRAP_FLAG && !(ACCESS.valid && ACCESS.unaligned && (TRAP_EN || ACCESS.kind != UAF_KIND_SINGLE)))
    |=> !UNALIGNED_TRAP_FLAG)
    else $error("flag set without a trapping access");

  // With trapping on every unaligned access faults
  fault_sets_a : assert property (@(posedge CLK) disable iff (!RST_N)
    (ACCESS.valid && ACCESS.unaligned && TRAP_EN) |=> (UNALIGNED_TRAP_FLAG && FAULT_PULSE))
    else $error("enabled unaligned access did not fault");

  // Single access with trapping on sets the flag
  single_on_a : assert property (@(posedge CLK) disable iff (!RST_N)
    (ACCESS.valid && ACCESS.unaligned && ACCESS.kind == UAF_KIND_SINGLE && TRAP_EN) |=> UNALIGNED_TRAP_FLAG)
    else $error("trapped single access did not set flag");

  // Single access with trapping off completes quietly
  single_off_a : assert property (@(posedge CLK) disable iff (!RST_N)
    (ACCESS.valid && ACCESS.unaligned && ACCESS.kind == UAF_KIND_SINGLE && !TRAP_EN && !UNALIGNED_TRAP_FLAG)
    |=> !UNALIGNED_TRAP_FLAG)
    else $error("untrapped single access set flag");

  // Wide transfers strobe the fault even with trapping off
  wide_no_enable_a : assert property (@(posedge CLK) disable iff (!RST_N)
    (ACCESS.valid && ACCESS.unaligned && !TRAP_EN &&
     (ACCESS.kind == UAF_KIND_MULTI || ACCESS.kind == UAF_KIND_DUAL)) |=> FAULT_PULSE)
    else $error("wide unaligned access gave no fault strobe");

  // Aligned accesses never fault
  aligned_ignored_a : assert property (@(posedge CLK) disable iff (!RST_N)
    (ACCESS.valid && !ACCESS.unaligned && !UNALIGNED_TRAP_FLAG) |=> (!UNALIGNED_TRAP_FLAG && !FAULT_PULSE))
    else $error("aligned access faulted");

  // No report, no fault
  invalid_ignored_a : assert property (@(posedge CLK) disable iff (!RST_N)
    (!ACCESS.valid && !UNALIGNED_TRAP_FLAG) |=> (!UNALIGNED_TRAP_FLAG && !FAULT_PULSE))
    else $error("flag set with no access reported");

  // The enable alone must not set anything
  enable_no_effect_a : assert property (@(posedge CLK) disable iff (!RST_N)
    (TRAP_EN && !ACCESS.valid && !UNALIGNED_TRAP_FLAG) |=> !UNALIGNED_TRAP_FLAG)
    else $error("trap enable alone set flag");

  // Every rise of the flag traces back to a fault
  rise_needs_fault_a : assert property (@(posedge CLK) disable iff (!RST_N)
    $rose(UNALIGNED_TRAP_FLAG) |-> $past(fault))
    else $error("flag rose without a fault");

  // ----------------------------------------------------------------------
  // Checks: clearing and holding
  // ----------------------------------------------------------------------
  // Write one with no fault in the same cycle clears
  w1c_clear_a : assert property (@(posedge CLK) disable iff (!RST_N)
    (clr_hit && !fault) |=> !UNALIGNED_TRAP_FLAG)
    else $error("write one did not clear flag");

  // Without a write one the flag holds
  w0_keeps_a : assert property (@(posedge CLK) disable iff (!RST_N)
    (UNALIGNED_TRAP_FLAG && !clr_hit) |=> UNALIGNED_TRAP_FLAG)
    else $error("flag dropped without write one");

  // Zero in the flag's bit leaves it alone
  zero_write_keeps_a : assert property (@(posedge CLK) disable iff (!RST_N)
    (UNALIGNED_TRAP_FLAG && WR.wr_en && !WR.wdata[UAF_FLAG_BIT]) |=> UNALIGNED_TRAP_FLAG)
    else $error("write zero cleared flag");

  // Writes to other offsets leave it alone
  wrong_addr_keeps_a : assert property (@(posedge CLK) disable iff (!RST_N)
    (UNALIGNED_TRAP_FLAG && WR.wr_en && WR.addr != UAF_STATUS_OFFSET) |=> UNALIGNED_TRAP_FLAG)
    else $error("write to another offset cleared flag");

  // Set wins so a fault in the clearing cycle is kept
  set_wins_a : assert property (@(posedge CLK) disable iff (!RST_N)
    (clr_hit && fault) |=> UNALIGNED_TRAP_FLAG)
    else $error("clear beat a simultaneous fault");

  // A repeat fault on a set flag keeps it set
  sticky_fault_a : assert property (@(posedge CLK) disable iff (!RST_N)
    (UNALIGNED_TRAP_FLAG && fault) |=> UNALIGNED_TRAP_FLAG)
    else $error("repeat fault dropped flag");

  // Only a write one or a reset may lower the flag
  fall_needs_clear_a : assert property (@(posedge CLK) disable iff (!RST_N)
    $fell(UNALIGNED_TRAP_FLAG) |-> ($past(clr_hit) || !$past(RST_N)))
    else $error("flag fell without clear or reset");

  // ----------------------------------------------------------------------
  // Checks: reset and strobe
  // ----------------------------------------------------------------------
  // Reset forces the flag low on the next edge
  reset_zero_a : assert property (@(posedge CLK)
    !RST_N |=> !UNALIGNED_TRAP_FLAG)
    else $error("flag not zero after reset");

  // Reset forces the strobe low as well
  reset_pulse_a : assert property (@(posedge CLK)
    !RST_N |=> !FAULT_PULSE)
    else $error("fault strobe not zero after reset");

  // The strobe is never high without the flag
  pulse_match_a : assert property (@(posedge CLK) disable iff (!RST_N)
    FAULT_PULSE |-> UNALIGNED_TRAP_FLAG)
    else $error("fault pulse without flag");

  // Each fault gives a strobe one cycle later
  pulse_follows_a : assert property (@(posedge CLK) disable iff (!RST_N)
    fault |=> FAULT_PULSE)
    else $error("fault gave no strobe");

  // No fault, no strobe, so the strobe lasts one cycle per fault
  no_pulse_quiet_a : assert property (@(posedge CLK) disable iff (!RST_N)
    !fault |=> !FAULT_PULSE)
    else $error("strobe without a fault");

endmodule : uaf_flag

`default_nettype wire

//--- rtl/uaf_pkg.sv
/*
  Shared constants and carrier types for the unaligned access fault flag.
  Assumes a single processor clock and that the load/store unit reports
  accesses as one-cycle pulses on the same clock.
*/
package uaf_pkg;

  // ----------------------------------------------------------------------
  // Fault status layout
  // ----------------------------------------------------------------------
  localparam logic [11:0] UAF_STATUS_OFFSET = 12'hd28;  // Status word offset
  localparam int          UAF_FLAG_BIT      = 24;       // Flag position
  localparam logic        UAF_FLAG_RESET    = 1'h0;     // Flag reset value

  // Access kind reported with each load/store
  typedef enum logic [2:0] {
    UAF_KIND_SINGLE = 3'h1,
    UAF_KIND_MULTI  = 3'h2,
    UAF_KIND_DUAL   = 3'h4
  } uaf_kind_t;

  // Access report from the load/store logic
  typedef struct packed {
    logic      valid;
    logic      unaligned;
    uaf_kind_t kind;
  } uaf_access_t;

  // Register write path into the status word
  typedef struct packed {
    logic        wr_en;
    logic [11:0] addr;
    logic [31:0] wdata;
  } uaf_wr_t;

endpackage : uaf_pkg

//--- rtl/uaf_trap_decide.sv
/*
  Decides whether a reported access raises an unaligned usage fault.
  Assumes the access report and enable come from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module uaf_trap_decide
  import uaf_pkg::*;
(
  // Access report
  input  wire uaf_pkg::uaf_access_t acc,
  // Trap enable from the control register
  input  wire logic                 trap_en,
  // Fault decision
  output logic                      fault
);

  // ----------------------------------------------------------------------
  // Decision
  // ----------------------------------------------------------------------
  logic multi_or_dual;

  // Unaligned multi and dual transfers cannot be split, so they always fault
  always_comb
  begin
    multi_or_dual = (acc.kind == UAF_KIND_MULTI) || (acc.kind == UAF_KIND_DUAL);
    fault = acc.valid && acc.unaligned && (multi_or_dual || trap_en);
  end

endmodule : uaf_trap_decide

`default_nettype wire

//--- dv/unaligned_access_fault_flag_test.sv
/*
  Self-checking bench for the unaligned trap flag.
  Assumes uaf_pkg and uaf_flag from rtl/ are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module unaligned_access_fault_flag_test;
  import uaf_pkg::*;
  // ----------------------------------------
  // Stimulus, clock and design
  // ----------------------------------------
  localparam logic [31:0] CLR = 32'h1 << UAF_FLAG_BIT;
  logic        clk      = 1'b0;
  logic        rst_n    = 1'b0;
  uaf_access_t acc      = '0;
  logic        en       = 1'b0;
  uaf_wr_t     wr       = '0;
  logic        flag;
  logic        pulse;
  int          fails    = 0;
  int          compares = 0;
  int          cycles   = 0;

  always #5 clk = ~clk;

  uaf_flag u_uaf_flag (.CLK(clk), .RST_N(rst_n), .ACCESS(acc), .TRAP_EN(en), .WR(wr),
                       .UNALIGNED_TRAP_FLAG(flag), .FAULT_PULSE(pulse));

  // Hang guard, far above the sixty or so cycles used
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      fails++;
      print_verdict();
    end
  end

  task automatic chk(input string what, input logic seen, input logic exp);
    compares++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch %s expected %b seen %b", what, exp, seen);
    end
  endtask : chk

  // One report; pulse must last exactly one cycle
  task automatic hit(input logic un, input uaf_kind_t k, input logic te, input logic f);
    en  = te;
    acc = '{1'b1, un, k};
    @(negedge clk);
    acc = '0;
    chk("flag", flag, f);
    chk("pulse", pulse, un && (k != UAF_KIND_SINGLE || te));
    @(negedge clk);
    chk("pulse drop", pulse, 1'b0);
  endtask : hit

  task automatic put(input logic [11:0] a, input logic [31:0] d, input logic f);
    wr = '{1'b1, a, d};
    @(negedge clk);
    wr = '0;
    @(negedge clk);
    chk("flag after write", flag, f);
  endtask : put

  task automatic rst(input int n);
    rst_n = 1'b0;
    repeat (n) @(negedge clk);
    rst_n = 1'b1;
    chk("reset flag", flag, UAF_FLAG_RESET);
    chk("reset pulse", pulse, 1'b0);
  endtask : rst

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_single;
    hit(1'b1, UAF_KIND_SINGLE, 1'b0, 1'b0);
    hit(1'b0, UAF_KIND_SINGLE, 1'b1, 1'b0);
    hit(1'b1, UAF_KIND_SINGLE, 1'b1, 1'b1);
    put(UAF_STATUS_OFFSET, CLR, 1'b0);
  endtask : t_single

  // Wide transfers fault with trapping off
  task automatic t_always;
    uaf_kind_t ks[2] = '{UAF_KIND_MULTI, UAF_KIND_DUAL};
    foreach (ks[i])
    begin
      hit(1'b0, ks[i], 1'b0, 1'b0);
      hit(1'b1, ks[i], 1'b0, 1'b1);
      put(UAF_STATUS_OFFSET, CLR, 1'b0);
    end
  endtask : t_always

  task automatic t_clear;
    hit(1'b1, UAF_KIND_MULTI, 1'b1, 1'b1);
    put(12'hd2c, CLR, 1'b1);
    put(UAF_STATUS_OFFSET, ~CLR, 1'b1);
    hit(1'b1, UAF_KIND_DUAL, 1'b1, 1'b1);
    put(UAF_STATUS_OFFSET, CLR, 1'b0);
    hit(1'b1, UAF_KIND_SINGLE, 1'b1, 1'b1);
    rst(2);
  endtask : t_clear

  // Fault and write one in one cycle on a set flag: set wins
  task automatic t_race;
    hit(1'b1, UAF_KIND_DUAL, 1'b0, 1'b1);
    en  = 1'b1;
    acc = '{1'b1, 1'b1, UAF_KIND_SINGLE};
    wr  = '{1'b1, UAF_STATUS_OFFSET, CLR};
    @(negedge clk);
    acc = '0;
    wr  = '0;
    chk("flag set wins", flag, 1'b1);
    chk("race pulse", pulse, 1'b1);
    @(negedge clk);
    chk("race pulse drop", pulse, 1'b0);
    put(UAF_STATUS_OFFSET, CLR, 1'b0);
  endtask : t_race

  task automatic print_verdict;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict

  initial
  begin
    rst(20);
    t_single();
    t_always();
    t_clear();
    t_race();
    print_verdict();
  end
endmodule : unaligned_access_fault_flag_test

`default_nettype wire
